// file: logic/cmpc_pkg.sv
package cmpc_pkg;

   // Register word offsets (byte addresses on the 32-bit bus).
   localparam logic [3:0] CMPC_OFS_CONTROL_1    = 4'h0;
   localparam logic [3:0] CMPC_OFS_CONTROL_2    = 4'h4;
   localparam logic [3:0] CMPC_OFS_PIN_DISABLE  = 4'h8;
   localparam logic [3:0] CMPC_OFS_IRQ_CONTROL  = 4'hC;

   localparam int CMPC_ADDR_W = 4;

   // Field positions of comparator_control_1.
   localparam int CMPC_C1_SWAP   = 7;
   localparam int CMPC_C1_RSEL   = 6;
   localparam int CMPC_C1_REF_HI = 5;
   localparam int CMPC_C1_REF_LO = 4;
   localparam int CMPC_C1_POWER  = 3;
   localparam int CMPC_C1_EDGE   = 2;
   localparam int CMPC_C1_IRQEN  = 1;
   localparam int CMPC_C1_FLAG   = 0;

   // Field positions of comparator_control_2.
   localparam int CMPC_C2_PIN_B  = 3;
   localparam int CMPC_C2_PIN_A  = 2;
   localparam int CMPC_C2_FILT   = 1;
   localparam int CMPC_C2_RESULT = 0;

   // Field positions of the interrupt control word.
   localparam int CMPC_IC_GIE    = 0;
   localparam int CMPC_IC_ACK    = 1;

   localparam logic [7:0] CMPC_RESET_BYTE = 8'h00;
   localparam logic [7:0] CMPC_C2_RW_MASK = 8'h0E;
   localparam logic [31:0] CMPC_READ_ZERO = 32'h0000_0000;

   typedef enum logic [1:0]
   {
      CMPC_REF_OFF,
      CMPC_REF_QUARTER,
      CMPC_REF_HALF,
      CMPC_REF_DIODE
   } cmpc_ref_level_t;

   typedef struct packed
   {
      logic            comparatorPowerEnable;
      logic            swapInputs;
      logic            refToPlus;
      logic            refToMinus;
      cmpc_ref_level_t referenceLevel;
      logic            pinToInputA;
      logic            pinToInputB;
      logic            outputFilterEnable;
      logic [7:0]      pinBufferDisable;
   } cmpc_analog_ctl_t;

endpackage

// file: logic/cmpc_control_regs.sv
// Behaviour
// - Bit 7 of control 1 swaps comparator inputs and inverts the output.
// - Bit 6 picks reference terminal: 0 plus, 1 minus; swap reverses it.
// - Bits 5-4 choose reference: off, quarter supply, half supply, diode.
// - Bit 3 powers the comparator; reference is enabled independently.
// - Bit 2 chooses flag edge: 0 rising, 1 falling.
// - Bit 1 enables the comparator interrupt request.
// - Bit 0 of control 1 is the pending interrupt flag.
// - Control 1 resets to zero and is fully readable and writable.
// - Control 2 bit 3 connects its pin to comparator input b.
// - Control 2 bit 2 connects its pin to comparator input a.
// - Control 2 bit 1 routes the output through the RC filter.
// - Control 2 bit 0 reads the comparator output; writes ignored.
// - Control 2 bits 7-4 unused; writable bits and output reset to zero.
// - Buffer-disable bit n set disables port pin n input buffer.
// - Output is forced low while the comparator is powered off.
// - Flag sets on chosen edge; request needs local and global enables.
// - Flag clears when the request is serviced or by software write.
module cmpc_control_regs
   import cmpc_pkg::*;
#(
   parameter int PIN_COUNT = 8
)
(
   input  wire logic                   clock,
   input  wire logic                   arst_n,
   input  wire logic                   wb_cyc_i,
   input  wire logic                   wb_stb_i,
   input  wire logic                   wb_we_i,
   input  wire logic [CMPC_ADDR_W-1:0] wb_adr_i,
   input  wire logic [3:0]             wb_sel_i,
   input  wire logic [31:0]            wb_dat_i,
   output logic      [31:0]            wb_dat_o,
   output logic                        wb_ack_o,
   input  wire logic                   comparatorRaw,
   output cmpc_analog_ctl_t            analogCtl,
   output logic                        irqRequest
);

   // The buffer-disable register is one byte, so only eight pins can be served.
   if (PIN_COUNT != 8)
      $error("cmpc_control_regs: buffer-disable register is eight bits wide");

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode. Answer comes one cycle after the request; ack drops next.

   logic       access;
   logic       writeHit;
   logic       laneWrite;
   logic [7:0] control1;
   logic [7:0] control2;
   logic [7:0] pinDisable;
   logic       globalIrqEnable;
   logic       syncStage;
   logic       syncOut;
   logic       syncLast;
   logic       compResult;
   logic       edgeSeen;
   logic       serviceAck;

   assign access    = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign writeHit  = access && wb_we_i;
   assign laneWrite = writeHit && wb_sel_i[0];

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= access;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Comparator output synchroniser and edge detection.

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         syncStage <= 1'b0;
         syncOut   <= 1'b0;
         syncLast  <= 1'b0;
      end
      else
      begin
         syncStage <= comparatorRaw;
         syncOut   <= syncStage;
         syncLast  <= compResult;
      end
   end

   // The analog core keeps its output level when unpowered, so the gating forces
   // it low here and also masks the synchroniser tail right after power-off.
   assign compResult = control1[CMPC_C1_POWER]
                     & (syncOut ^ control1[CMPC_C1_SWAP]);

   assign edgeSeen = control1[CMPC_C1_EDGE]
                   ? (syncLast && !compResult)
                   : (!syncLast && compResult);

   assign serviceAck = writeHit && (wb_adr_i == CMPC_OFS_IRQ_CONTROL)
                     && wb_sel_i[0] && wb_dat_i[CMPC_IC_ACK];

   ////////////////////////////////////////////////////////////////////////////
   // Control register 1. A detected edge wins over a clear in the same cycle.

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         control1 <= CMPC_RESET_BYTE;
      else
      begin
         if (laneWrite && (wb_adr_i == CMPC_OFS_CONTROL_1))
            control1 <= wb_dat_i[7:0];
         else if (serviceAck)
            control1[CMPC_C1_FLAG] <= 1'b0;
         if (edgeSeen)
            control1[CMPC_C1_FLAG] <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control register 2, buffer disables and global enable.

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         control2 <= CMPC_RESET_BYTE;
      else if (laneWrite && (wb_adr_i == CMPC_OFS_CONTROL_2))
         control2 <= wb_dat_i[7:0] & CMPC_C2_RW_MASK;
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         pinDisable <= CMPC_RESET_BYTE;
      else if (laneWrite && (wb_adr_i == CMPC_OFS_PIN_DISABLE))
         pinDisable <= wb_dat_i[7:0];
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         globalIrqEnable <= 1'b0;
      else if (laneWrite && (wb_adr_i == CMPC_OFS_IRQ_CONTROL))
         globalIrqEnable <= wb_dat_i[CMPC_IC_GIE];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data, registered with the ack. Unmapped words read zero.

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         wb_dat_o <= CMPC_READ_ZERO;
      else if (access && !wb_we_i)
      begin
         wb_dat_o <= CMPC_READ_ZERO;
         case (wb_adr_i)
            CMPC_OFS_CONTROL_1:   wb_dat_o[7:0] <= control1;
            CMPC_OFS_CONTROL_2:   wb_dat_o[7:0] <= {control2[7:1], compResult};
            CMPC_OFS_PIN_DISABLE: wb_dat_o[7:0] <= pinDisable;
            CMPC_OFS_IRQ_CONTROL: wb_dat_o[CMPC_IC_GIE] <= globalIrqEnable;
            default:              wb_dat_o <= CMPC_READ_ZERO;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Analog controls and interrupt request.

   always_comb
   begin
      analogCtl.comparatorPowerEnable = control1[CMPC_C1_POWER];
      analogCtl.swapInputs            = control1[CMPC_C1_SWAP];
      analogCtl.refToPlus  = control1[CMPC_C1_RSEL] == control1[CMPC_C1_SWAP];
      analogCtl.refToMinus = control1[CMPC_C1_RSEL] != control1[CMPC_C1_SWAP];
      analogCtl.referenceLevel = cmpc_ref_level_t'(
         control1[CMPC_C1_REF_HI:CMPC_C1_REF_LO]);
      analogCtl.pinToInputA        = control2[CMPC_C2_PIN_A];
      analogCtl.pinToInputB        = control2[CMPC_C2_PIN_B];
      analogCtl.outputFilterEnable = control2[CMPC_C2_FILT];
      analogCtl.pinBufferDisable   = pinDisable;
   end

   assign irqRequest = control1[CMPC_C1_FLAG] && control1[CMPC_C1_IRQEN]
                     && globalIrqEnable;

endmodule // cmpc_control_regs

// file: bench/cmpc_analog_model.sv
module cmpc_analog_model
   import cmpc_pkg::*;
(
   input  wire logic       aboveIn,
   input  cmpc_analog_ctl_t analogCtl,
   output logic            comparatorRaw
);
   timeunit 1ns;
   timeprecision 1ps;
   // The core keeps its level when powered down; masking it is the block's job.
   assign #3 comparatorRaw = aboveIn;
endmodule // cmpc_analog_model

// file: bench/cmpc_control_regs_assertions.sv
module cmpc_control_regs_assertions
   import cmpc_pkg::*;
(
   input wire logic                   clock,
   input wire logic                   arst_n,
   input wire logic                   wb_cyc_i,
   input wire logic                   wb_stb_i,
   input wire logic                   wb_we_i,
   input wire logic [CMPC_ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0]             wb_sel_i,
   input wire logic [31:0]            wb_dat_i,
   input wire logic [31:0]            wb_dat_o,
   input wire logic                   wb_ack_o,
   input cmpc_analog_ctl_t            analogCtl
);
   timeunit 1ns;
   timeprecision 1ps;
   logic wr;
   logic rd;
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
   assign rd = wb_ack_o && !wb_we_i;
   default clocking @(posedge clock);
   endclocking
   default disable iff (!arst_n);
   ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held");
   ctl1_write_a: assert property (wr && wb_adr_i == CMPC_OFS_CONTROL_1 |=>
      analogCtl.swapInputs == $past(wb_dat_i[7]) && analogCtl.referenceLevel == $past(wb_dat_i[5:4])
      && analogCtl.comparatorPowerEnable == $past(wb_dat_i[3])) else $error("ctl1 decode");
   ref_term_a: assert property (wr && wb_adr_i == CMPC_OFS_CONTROL_1 |=>
      analogCtl.refToPlus == ($past(wb_dat_i[6]) == $past(wb_dat_i[7]))
      && analogCtl.refToMinus == ($past(wb_dat_i[6]) != $past(wb_dat_i[7])))
      else $error("ref term");
   ctl2_write_a: assert property (wr && wb_adr_i == CMPC_OFS_CONTROL_2 |=>
      {analogCtl.pinToInputB, analogCtl.pinToInputA, analogCtl.outputFilterEnable}
      == $past(wb_dat_i[3:1])) else $error("ctl2 decode");
   pin_write_a: assert property (wr && wb_adr_i == CMPC_OFS_PIN_DISABLE |=>
      analogCtl.pinBufferDisable == $past(wb_dat_i[7:0])) else $error("pin disable");
   upper_zero_a: assert property (rd |-> wb_dat_o[31:8] == 24'h000000)
      else $error("upper bits set");
   power_low_a: assert property (rd && wb_adr_i == CMPC_OFS_CONTROL_2 &&
      !analogCtl.comparatorPowerEnable && !$past(analogCtl.comparatorPowerEnable, 3)
      |-> !wb_dat_o[0]) else $error("output while off");
endmodule // cmpc_control_regs_assertions

// file: bench/testbench.sv
module testbench;
   import cmpc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0, arst_n = 1'b0, cyc = 1'b0, we = 1'b0, above = 1'b0;
   logic [3:0] adr = 4'h0, sel = 4'h0;
   logic [31:0] wdat = 32'h0, got, seed = 32'h2B;
   logic ack, raw, irq;
   logic [31:0] rdat;
   cmpc_analog_ctl_t ctl;
   int nMismatch = 0, numChecks = 0, exp1 = 0, exp2 = 0, expP = 0;
   always #12.5 clock = ~clock;
   cmpc_control_regs i_cmpc_control_regs (.clock(clock), .arst_n(arst_n), .wb_cyc_i(cyc),
      .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .comparatorRaw(raw), .analogCtl(ctl), .irqRequest(irq));
   cmpc_analog_model i_cmpc_analog_model (.aboveIn(above), .analogCtl(ctl), .comparatorRaw(raw));
   task automatic completeRun();
      if (nMismatch == 0 && numChecks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      numChecks++;
      if (g !== e)
      begin
         nMismatch++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] s);
      @(posedge clock);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, d};
      sel <= s;
      do @(posedge clock); while (ack !== 1'b1);
      got = rdat;
      cyc <= 1'b0;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] s);
      bus(1'b1, a, d, s);
      if (s[0] && a == 4'h0) exp1 = d;
      if (s[0] && a == 4'h4) exp2 = d & 8'h0E;
      if (s[0] && a == 4'h8) expP = d;
   endtask
   task automatic rd(input logic [3:0] a, input int e);
      bus(1'b0, a, 8'h00, 4'hF);
      chk(got, 32'(e));
   endtask
   task automatic settle(input logic v);
      @(posedge clock);
      above <= v;
      repeat (8) @(posedge clock);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (16) @(posedge clock);
      arst_n <= 1'b1;
      rd(4'h0, 0);
      rd(4'h4, 0);
      // Swap and flag stay clear here so that no output edge can raise the flag.
      repeat (8)
      begin
         seed ^= seed << 13;
         seed ^= seed >> 17;
         seed ^= seed << 5;
         wr(4'h0, seed[7:0] & 8'h76, seed[11:8]);
         wr(4'h4, seed[19:12], seed[23:20]);
         wr(4'h8, seed[31:24], seed[15:12]);
         rd(4'h0, exp1);
         rd(4'h4, exp2);
         rd(4'h8, expP);
      end
      wr(4'h0, 8'h0A, 4'hF);
      wr(4'hC, 8'h01, 4'hF);
      settle(1'b1);
      rd(4'h0, 8'h0B);
      chk({31'h0, irq}, 32'h1);
      wr(4'hC, 8'h03, 4'hF);
      rd(4'h0, 8'h0A);
      wr(4'h0, 8'h0E, 4'hF);
      settle(1'b0);
      rd(4'h0, 8'h0F);
      wr(4'h0, 8'h8A, 4'hF);
      settle(1'b0);
      rd(4'h4, exp2 | 1);
      rd(4'h0, 8'h8B);
      // Flag pending with the local enable clear must not request an interrupt.
      wr(4'h0, 8'h89, 4'hF);
      rd(4'h0, 8'h89);
      chk({31'h0, irq}, 32'h0);
      wr(4'h0, 8'h00, 4'hF);
      settle(1'b1);
      rd(4'h4, exp2);
      chk({31'h0, irq}, 32'h0);
      completeRun();
   end
   initial
   begin
      repeat (3000) @(posedge clock);
      nMismatch++;
      completeRun();
   end
endmodule // testbench
bind cmpc_control_regs cmpc_control_regs_assertions i_cmpc_control_regs_assertions (
   .clock(clock), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .analogCtl(analogCtl));
